// >>> rtl/sesp_pkg.sv
// shared constants and types for the serial eeprom status and protection block
package sesp_pkg;
   // opcodes, msb first on the serial input
   localparam logic [7:0] SESP_OP_LATCH_SET = 8'h06;
   localparam logic [7:0] SESP_OP_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] SESP_OP_STATUS_READ = 8'h05;
   localparam logic [7:0] SESP_OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] SESP_OP_ARRAY_WRITE = 8'h02;
   localparam logic [7:0] SESP_OP_ID_WRITE = 8'h82;
   // status byte field positions
   localparam int SESP_BIT_BUSY = 0;
   localparam int SESP_BIT_LATCH = 1;
   localparam int SESP_BIT_PROT_LO = 2;
   localparam int SESP_BIT_PROT_HI = 3;
   localparam int SESP_BIT_LOCK = 7;
   // reset values of the stored protection bits (delivery state)
   localparam logic [1:0] SESP_PROT_RST = 2'h0;
   localparam logic SESP_LOCK_RST = 1'b0;
   // array region limits, 19-bit byte addresses
   localparam logic [18:0] SESP_ADDR_TOP = 19'h7ffff;
   localparam logic [18:0] SESP_BASE_QUARTER = 19'h60000;
   localparam logic [18:0] SESP_BASE_HALF = 19'h40000;
   localparam logic [18:0] SESP_BASE_ALL = 19'h00000;
   // self-timed write cycle
   localparam int SESP_CLK_MHZ = 250;
   localparam int SESP_TW_US = 5000;
   localparam int SESP_TW_CYCLES = SESP_TW_US * SESP_CLK_MHZ;

   typedef struct packed {
      logic lock;
      logic [1:0] prot;
   } sesp_nv_t;

   // spi pins as seen by the device
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic mosi;
   } sesp_spi_t;
endpackage : sesp_pkg

// >>> rtl/sesp_status_protect.sv
// status register and write protection control of a serial eeprom
//
// How it works
// - latch set only by latch-set opcode
// - latch-set waits for deselect before acting
// - latch-clear acts after deselect
// - latch cleared at reset, clear, write end
// - status read accepted even while busy
// - status byte repeats while still selected
// - busy high from accepted deselect to cycle end
// - write opcodes discarded when latch clear
// - protect bits only via status write
// - lock bit and pin low block status writes
// - status write needs latch set first
// - deselect exactly at data byte boundary
// - accepted deselect starts timed write cycle
// - latch cleared when status cycle ends
// - new protect values apply after cycle
// - unused bits dropped, b6..b4 read zero
// - lock clear allows writes any pin level
// - lock set, pin high still allows writes
// - hardware lock when lock bit set and pin low
// - hardware lock left by pin high, by reset, or by a cycle end that clears lock
// - protected region refuses array writes
// - bytes shifted most significant bit first
// - four opcodes decoded, others idle out
// - protect codes map to upper regions
`timescale 1ns/1ps
`default_nettype none
module sesp_status_protect
   import sesp_pkg::*;
#(
   parameter int TW_CYCLES = sesp_pkg::SESP_TW_CYCLES
)(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // spi pins from the master
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_wp_n,
   // serial output, two signals for the shared data line
   output logic o_miso,
   output logic o_miso_oe,
   // array write request from the array engine and its verdict
   input wire logic i_arr_wr_req,
   input wire logic [18:0] i_arr_wr_addr,
   output logic o_arr_wr_ok,
   output logic o_arr_wr_refused,
   // protection state
   output logic o_hardware_lock_mode,
   output logic o_busy_flag,
   output logic [7:0] o_protection_status
);
   import sesp_pkg::*;

   typedef enum {ST_OPCODE, ST_DATA, ST_READ, ST_WAIT} sesp_state_t;

   sesp_spi_t meta_r;
   sesp_spi_t sync_r;
   sesp_spi_t prev_r;
   logic wp_meta_r;
   logic wp_r;
   sesp_state_t state_r;
   logic [7:0] shift_r;
   logic [2:0] bit_cnt_r;
   logic byte_done_r;
   logic [7:0] rd_shift_r;
   logic [2:0] rd_cnt_r;
   logic rd_active_r;
   logic [7:0] opcode_r;
   logic latch_r;
   logic busy_r;
   logic [31:0] tw_cnt_r;
   sesp_nv_t nv_r;
   sesp_nv_t pend_r;
   logic pend_valid_r;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic cs_fall;
   logic hw_lock;
   logic [7:0] status_byte;
   logic [7:0] byte_in;

   // protected-region hit test for a protect code, used by the write check
   function automatic logic prot_hit(input logic [1:0] code, input logic [18:0] addr);
      logic hit;
      hit = 1'b0;
      unique case (code)
         2'h0: hit = 1'b0;
         2'h1: hit = (addr >= SESP_BASE_QUARTER) && (addr <= SESP_ADDR_TOP);
         2'h2: hit = (addr >= SESP_BASE_HALF) && (addr <= SESP_ADDR_TOP);
         2'h3: hit = (addr >= SESP_BASE_ALL) && (addr <= SESP_ADDR_TOP);
      endcase
      return hit;
   endfunction : prot_hit

   // two flops on every pin before use
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         meta_r <= '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
         sync_r <= '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
         prev_r <= '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
         wp_meta_r <= 1'b1;
         wp_r <= 1'b1;
      end
      else
      begin
         meta_r <= '{cs_n: i_cs_n, sck: i_sck, mosi: i_mosi};
         sync_r <= meta_r;
         prev_r <= sync_r;
         wp_meta_r <= i_wp_n;
         wp_r <= wp_meta_r;
      end
   end

   assign sck_rise = sync_r.sck & ~prev_r.sck & ~sync_r.cs_n;
   assign sck_fall = ~sync_r.sck & prev_r.sck & ~sync_r.cs_n;
   assign cs_rise = sync_r.cs_n & ~prev_r.cs_n;
   assign cs_fall = ~sync_r.cs_n & prev_r.cs_n;
   assign byte_in = {shift_r[6:0], sync_r.mosi};

   // hardware lock whenever the lock bit is set and the pin is low
   assign hw_lock = nv_r.lock & ~wp_r;

   always_comb
   begin
      status_byte = 8'h00;
      status_byte[SESP_BIT_BUSY] = busy_r;
      status_byte[SESP_BIT_LATCH] = latch_r;
      status_byte[SESP_BIT_PROT_LO] = nv_r.prot[0];
      status_byte[SESP_BIT_PROT_HI] = nv_r.prot[1];
      status_byte[SESP_BIT_LOCK] = nv_r.lock;
   end

   // bit counter and input shifter
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || sync_r.cs_n)
      begin
         shift_r <= 8'h00;
         bit_cnt_r <= 3'h0;
         byte_done_r <= 1'b0;
      end
      else if (sck_rise)
      begin
         shift_r <= byte_in;
         bit_cnt_r <= bit_cnt_r + 3'h1;
         // marks a byte boundary until the next rising edge
         byte_done_r <= (bit_cnt_r == 3'h7);
      end
   end

   // command sequencer
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         state_r <= ST_OPCODE;
         opcode_r <= 8'h00;
         pend_r <= '{lock: SESP_LOCK_RST, prot: SESP_PROT_RST};
         pend_valid_r <= 1'b0;
      end
      else if (sync_r.cs_n)
      begin
         // deselect ends any instruction
         state_r <= ST_OPCODE;
         pend_valid_r <= 1'b0;
      end
      else if (sck_rise && bit_cnt_r == 3'h7)
      begin
         unique case (state_r)
            ST_OPCODE:
            begin
               opcode_r <= byte_in;
               // busy device only answers a status read
               if (byte_in == SESP_OP_STATUS_READ)
                  state_r <= ST_READ;
               else if (byte_in == SESP_OP_STATUS_WRITE && !busy_r)
                  state_r <= ST_DATA;
               else
                  // latch-set and latch-clear wait for deselect
                  state_r <= ST_WAIT;
            end
            ST_DATA:
            begin
               // keep only the stored bits
               pend_r <= '{lock: byte_in[SESP_BIT_LOCK],
                           prot: {byte_in[SESP_BIT_PROT_HI], byte_in[SESP_BIT_PROT_LO]}};
               pend_valid_r <= 1'b1;
               state_r <= ST_WAIT;
            end
            ST_READ: state_r <= ST_READ;
            ST_WAIT: state_r <= ST_WAIT;
         endcase
      end
      else if (sck_rise)
      begin
         // a later clock edge voids the status write
         pend_valid_r <= 1'b0;
      end
   end

   // write enable latch
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         latch_r <= 1'b0;
      else if (busy_r && tw_cnt_r == 32'h1)
         // cleared as the timed cycle ends
         latch_r <= 1'b0;
      else if (cs_rise && state_r == ST_WAIT && byte_done_r && !busy_r)
      begin
         // only the latch-set opcode sets it
         if (opcode_r == SESP_OP_LATCH_SET)
            latch_r <= 1'b1;
         else if (opcode_r == SESP_OP_LATCH_CLEAR)
            latch_r <= 1'b0;
      end
   end

   // self-timed write cycle and stored bits
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         busy_r <= 1'b0;
         tw_cnt_r <= 32'h0;
         // stands in for the non-volatile cells at power-up
         nv_r <= '{lock: SESP_LOCK_RST, prot: SESP_PROT_RST};
      end
      // accepted deselect at the byte boundary starts tw
      // locked with pin low rejects it
      else if (cs_rise && pend_valid_r && byte_done_r && latch_r && !hw_lock && !busy_r)
      begin
         busy_r <= 1'b1;
         tw_cnt_r <= TW_CYCLES;
      end
      else if (busy_r)
      begin
         tw_cnt_r <= tw_cnt_r - 32'h1;
         if (tw_cnt_r == 32'h1)
         begin
            busy_r <= 1'b0;
            // new values land only at cycle end
            nv_r <= pend_r;
         end
      end
   end

   // status read output, shifted on falling sck
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || sync_r.cs_n)
      begin
         rd_shift_r <= 8'h00;
         rd_cnt_r <= 3'h0;
         rd_active_r <= 1'b0;
      end
      else if (sck_fall && (state_r == ST_READ))
      begin
         // count wraps to zero while bit 0 still stands, so keep a flag
         rd_active_r <= 1'b1;
         // reload the live status at each byte start
         if (rd_cnt_r == 3'h0)
            rd_shift_r <= {status_byte[6:0], 1'b0};
         else
            rd_shift_r <= {rd_shift_r[6:0], 1'b0};
         rd_cnt_r <= rd_cnt_r + 3'h1;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_miso <= 1'b0;
         o_miso_oe <= 1'b0;
      end
      else
      begin
         o_miso_oe <= (state_r == ST_READ) && !sync_r.cs_n && (rd_active_r || sck_fall);
         if (sck_fall && state_r == ST_READ)
            o_miso <= (rd_cnt_r == 3'h0) ? status_byte[7] : rd_shift_r[7];
      end
   end

   // array write check for the array engine
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_arr_wr_ok <= 1'b0;
         o_arr_wr_refused <= 1'b0;
      end
      else
      begin
         // protected region refused in either mode
         o_arr_wr_ok <= i_arr_wr_req && latch_r && !busy_r
                        && !prot_hit(nv_r.prot, i_arr_wr_addr);
         o_arr_wr_refused <= i_arr_wr_req && !(latch_r && !busy_r
                             && !prot_hit(nv_r.prot, i_arr_wr_addr));
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_hardware_lock_mode <= 1'b0;
         o_busy_flag <= 1'b0;
         o_protection_status <= 8'h00;
      end
      else
      begin
         o_hardware_lock_mode <= hw_lock;
         o_busy_flag <= busy_r;
         o_protection_status <= status_byte;
      end
   end

endmodule : sesp_status_protect
`default_nettype wire

// >>> tb/sesp_status_protect_checker.sv
// port-level assertions for the status and protection block
`timescale 1ns/1ps
`default_nettype none
module sesp_status_protect_checker
   import sesp_pkg::*;
#(
   parameter int TW_CYCLES = 20
)(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // spi pins
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_wp_n,
   input wire logic o_miso,
   input wire logic o_miso_oe,
   // array write check
   input wire logic i_arr_wr_req,
   input wire logic [18:0] i_arr_wr_addr,
   input wire logic o_arr_wr_ok,
   input wire logic o_arr_wr_refused,
   // state
   input wire logic o_hardware_lock_mode,
   input wire logic o_busy_flag,
   input wire logic [7:0] o_protection_status
);
   logic in_prot;
   int busy_cnt;
   always_comb
   begin
      case (o_protection_status[3:2])
         2'h1: in_prot = i_arr_wr_addr >= SESP_BASE_QUARTER;
         2'h2: in_prot = i_arr_wr_addr >= SESP_BASE_HALF;
         2'h3: in_prot = 1'b1;
         default: in_prot = 1'b0;
      endcase
   end
   // cleared whenever idle, so its value at the fall is the busy length
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || !o_busy_flag)
         busy_cnt <= 0;
      else
         busy_cnt <= busy_cnt + 1;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   sequence deselected_s; i_cs_n[*5]; endsequence
   sequence wp_high_s; i_wp_n[*5]; endsequence
   zero_bits_a: assert property (o_protection_status[6:4] == 3'h0)
      else $error("status b6..b4 not zero");
   busy_mirror_a: assert property (o_busy_flag == o_protection_status[0])
      else $error("busy port differs from b0");
   hw_needs_lock_a: assert property (o_hardware_lock_mode |-> o_protection_status[7])
      else $error("hardware lock without lock bit");
   wp_high_free_a: assert property (wp_high_s |-> !o_hardware_lock_mode)
      else $error("hardware lock with pin high");
   busy_len_a: assert property ($fell(o_busy_flag) |->
      busy_cnt >= TW_CYCLES - 1 && busy_cnt <= TW_CYCLES + 1) else $error("busy length wrong");
   latch_end_a: assert property ($fell(o_busy_flag) |-> !o_protection_status[1])
      else $error("latch still set after write cycle");
   prot_stable_a: assert property (o_busy_flag && $past(o_busy_flag) |->
      $stable(o_protection_status[7:2])) else $error("protect bits moved while busy");
   idle_quiet_a: assert property (deselected_s |-> !o_miso_oe)
      else $error("serial out driven while deselected");
   latch_deselect_a: assert property ($rose(o_protection_status[1]) |->
      $past(i_cs_n, 1) && $past(i_cs_n, 2)) else $error("latch set while selected");
   busy_deselect_a: assert property ($rose(o_busy_flag) |-> $past(i_cs_n, 3))
      else $error("busy rose while selected");
   region_refused_a: assert property (i_arr_wr_req && in_prot |=>
      o_arr_wr_refused && !o_arr_wr_ok) else $error("protected write allowed");
   no_latch_a: assert property (i_arr_wr_req && !o_protection_status[1] |=> !o_arr_wr_ok)
      else $error("write allowed with latch clear");
endmodule : sesp_status_protect_checker
bind sesp_status_protect sesp_status_protect_checker #(.TW_CYCLES(TW_CYCLES))
   sesp_status_protect_checker_inst (.*);
`default_nettype wire

// >>> tb/sesp_spi_master.sv
// spi master model that sends instruction frames to the device
`timescale 1ns/1ps
`default_nettype none
module sesp_spi_master
(
   // clock and serial return
   input wire logic i_clk,
   input wire logic i_miso,
   // spi pins
   output logic o_cs_n,
   output logic o_sck,
   output logic o_mosi
);
   initial
   begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_mosi = 1'b0;
   end
   task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         o_mosi <= tx[i];
         repeat (4) @(posedge i_clk);
         o_sck <= 1'b1;
         repeat (4) @(posedge i_clk);
         // sampled late in the high phase: the output moves only after the fall
         rx[i] = i_miso;
         o_sck <= 1'b0;
      end
   endtask : shift_byte
   task automatic frame(input logic [7:0] op, input logic [7:0] data, input int nb,
                        output logic [7:0] rx);
      logic [7:0] junk;
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      shift_byte(op, junk);
      for (int k = 0; k < nb; k++)
         shift_byte(data, rx);
      repeat (4) @(posedge i_clk);
      o_cs_n <= 1'b1;
      // released line shows the inverse, never the last bit
      o_mosi <= ~o_mosi;
      repeat (8) @(posedge i_clk);
   endtask : frame
endmodule : sesp_spi_master
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the status and protection block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sesp_pkg::*;
   localparam int TW = 400;
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] data;
      logic wp_n;
      logic [7:0] exp;
   } sesp_row_t;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_wp_n = 1'b1;
   logic i_arr_wr_req = 1'b0;
   logic [18:0] i_arr_wr_addr = 19'h0;
   logic cs_n, sck, mosi, miso, miso_oe, wr_ok, wr_ref, hw_lock, busy;
   logic [7:0] status, rx;
   // released serial out reads as the inverse of the last bit
   logic miso_line;
   assign miso_line = miso_oe ? miso : ~miso;
   int bad_count = 0;
   int comparisons = 0;
   sesp_row_t rows [12] = '{
      '{SESP_OP_LATCH_SET, 8'h00, 1'b1, 8'h02},
      '{SESP_OP_LATCH_CLEAR, 8'h00, 1'b1, 8'h00},
      '{SESP_OP_STATUS_WRITE, 8'h8c, 1'b1, 8'h00},
      '{SESP_OP_LATCH_SET, 8'h00, 1'b1, 8'h02},
      '{SESP_OP_STATUS_WRITE, 8'hff, 1'b1, 8'h8c},
      '{SESP_OP_LATCH_SET, 8'h00, 1'b0, 8'h8e},
      '{SESP_OP_STATUS_WRITE, 8'h00, 1'b0, 8'h8e},
      '{SESP_OP_LATCH_SET, 8'h00, 1'b1, 8'h8e},
      '{SESP_OP_STATUS_WRITE, 8'h04, 1'b1, 8'h04},
      '{8'h9f, 8'h00, 1'b1, 8'h04},
      '{SESP_OP_LATCH_SET, 8'h00, 1'b0, 8'h06},
      '{SESP_OP_STATUS_WRITE, 8'h08, 1'b0, 8'h08}};
   always #2 i_ref_clk = ~i_ref_clk;
   sesp_spi_master sesp_spi_master_inst (.i_clk(i_ref_clk), .i_miso(miso_line), .o_cs_n(cs_n),
      .o_sck(sck), .o_mosi(mosi));
   sesp_status_protect #(.TW_CYCLES(TW)) sesp_status_protect_inst (.i_ref_clk(i_ref_clk),
      .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_mosi(mosi), .i_wp_n(i_wp_n),
      .o_miso(miso), .o_miso_oe(miso_oe), .i_arr_wr_req(i_arr_wr_req),
      .i_arr_wr_addr(i_arr_wr_addr), .o_arr_wr_ok(wr_ok), .o_arr_wr_refused(wr_ref),
      .o_hardware_lock_mode(hw_lock), .o_busy_flag(busy), .o_protection_status(status));
   task automatic test_done();
      $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
         bad_count++;
      end
   endtask : check
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 2000)
      begin
         @(posedge i_ref_clk);
         n++;
      end
      if (n >= 2000)
      begin
         $display("CHECK FAILED %0t busy never dropped", $time);
         bad_count++;
         test_done();
      end
   endtask : wait_idle
   task automatic run_row(input sesp_row_t r);
      @(posedge i_ref_clk);
      i_wp_n <= r.wp_n;
      sesp_spi_master_inst.frame(r.op, r.data, int'(r.op == SESP_OP_STATUS_WRITE), rx);
      wait_idle();
      sesp_spi_master_inst.frame(SESP_OP_STATUS_READ, 8'h00, 1, rx);
      check(rx, r.exp);
      check(status, r.exp);
      check({7'h0, hw_lock}, {7'h0, r.exp[7] & ~r.wp_n});
   endtask : run_row
   task automatic arr_check(input logic [18:0] addr, input logic ok);
      @(posedge i_ref_clk);
      i_arr_wr_req <= 1'b1;
      i_arr_wr_addr <= addr;
      repeat (2) @(posedge i_ref_clk);
      check({6'h0, wr_ok, wr_ref}, {6'h0, ok, ~ok});
      i_arr_wr_req <= 1'b0;
   endtask : arr_check
   initial
   begin
      repeat (20) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      check(status, 8'h00);
      check({5'h0, hw_lock, busy, wr_ok}, 8'h00);
      foreach (rows[i])
         run_row(rows[i]);
      run_row('{SESP_OP_LATCH_SET, 8'h00, 1'b1, 8'h0a});
      // read straight after the write, so the cycle is still running
      sesp_spi_master_inst.frame(SESP_OP_STATUS_WRITE, 8'h04, 1, rx);
      sesp_spi_master_inst.frame(SESP_OP_STATUS_READ, 8'h00, 2, rx);
      check(rx, 8'h0b);
      wait_idle();
      check(status, 8'h04);
      run_row('{SESP_OP_LATCH_SET, 8'h00, 1'b1, 8'h06});
      arr_check(19'h5ffff, 1'b1);
      arr_check(19'h60000, 1'b0);
      run_row('{SESP_OP_LATCH_CLEAR, 8'h00, 1'b1, 8'h04});
      arr_check(19'h00000, 1'b0);
      // data byte followed by a further byte: deselect is late, write void
      run_row('{SESP_OP_LATCH_SET, 8'h00, 1'b1, 8'h06});
      sesp_spi_master_inst.frame(SESP_OP_STATUS_WRITE, 8'h8c, 2, rx);
      repeat (8) @(posedge i_ref_clk);
      check(status, 8'h06);
      check({7'h0, busy}, 8'h00);
      // reset in mid-run, with a write cycle under way
      sesp_spi_master_inst.frame(SESP_OP_STATUS_WRITE, 8'h8c, 1, rx);
      check({7'h0, busy}, 8'h01);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      check(status, 8'h00);
      check({6'h0, hw_lock, busy}, 8'h00);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      check(status, 8'h00);
      run_row('{SESP_OP_LATCH_SET, 8'h00, 1'b1, 8'h02});
      test_done();
   end
endmodule : testbench
`default_nettype wire
